// File: dsmmu_core.sv
/*
  Data-stream fault capture, translation-buffer invalidation and data cache control.
  Assumes register moves come from privileged code and faults are reported one cycle wide.
*/
// How it works
// - Fault stores faulting opcode into syndrome bits 14:9.
// - Fault stores source register field into syndrome bits 8:4.
// - Syndrome bit 1 set on access violation.
// - Syndrome bit 0 set when faulting reference was a write.
// - Fault or buffer miss latches effective virtual address.
// - Capture locks address and syndrome until address is read.
// - Reset leaves address latch unlocked.
// - Syndrome changes only unlocked, on fault or buffer miss.
// - Reset leaves syndrome unlocked.
// - Invalidate-all write clears all small and large buffer entries.
// - Invalidate-all write also resets not-last-used pointer.
// - Non-global invalidate clears entries whose space-match bit is zero.
// - Single invalidate clears entry mapping the given virtual address.
// - Instruction cache flush write invalidates whole instruction cache.
// - Non-global icache write invalidates blocks with space-match clear.
// - Control bit 11 forces data hits, overriding enable.
// - Control bit 10 clear disables and flushes data cache.
// - Control bit 8 stops uncached references invalidating cache lines.
// - Control bit 6 inverts physical address bit 2 on data references.
module dsmmu_core #(
  parameter int VA_WIDTH = 43
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Fault report
  input  wire dsmmu_pkg::dsmmu_fault_s fault_in,
  input  wire logic [VA_WIDTH-1:0]   fault_va,
  // Register moves
  input  wire dsmmu_pkg::dsmmu_move_s move,
  input  wire logic [63:0]           move_wdata,
  output logic [63:0]                move_rdata,
  // Translation buffer commands
  output logic                       tb_inval_all,
  output logic                       tb_inval_nonglobal,
  output logic                       tb_inval_single,
  output logic [VA_WIDTH-1:0]        tb_inval_va,
  output logic                       nlu_pointer_reset,
  // Instruction cache commands
  output logic                       icache_inval_all,
  output logic                       icache_inval_nonglobal,
  // Data cache control
  output logic                       dcache_force_hit,
  output logic                       dcache_enable,
  output logic                       dcache_flush,
  output logic                       uncached_no_invalidate,
  output logic                       conditional_store_result_ctl,
  output logic                       big_endian_swap,
  // Physical address path
  input  wire logic                  pa_bit2_in,
  output logic                       pa_bit2_out,
  // Status
  output logic                       fault_locked
);

  logic [dsmmu_pkg::SYN_WIDTH-1:0] syn_q,  syn_d;
  logic [VA_WIDTH-1:0]             va_q,   va_d;
  logic                            lock_q, lock_d;
  logic [dsmmu_pkg::CTL_WIDTH-1:0] ctl_q,  ctl_d;
  logic                            cmd_all_q, cmd_all_d;
  logic                            cmd_ng_q,  cmd_ng_d;
  logic                            cmd_one_q, cmd_one_d;
  logic                            ic_all_q,  ic_all_d;
  logic                            ic_ng_q,   ic_ng_d;
  logic [VA_WIDTH-1:0]             inv_va_q,  inv_va_d;
  logic [63:0]                     rdata_q,   rdata_d;

  function automatic logic mv_wr(input dsmmu_pkg::dsmmu_move_s m, input logic [3:0] s);
    mv_wr = m.wr && (m.sel == s);
  endfunction

  function automatic logic mv_rd(input dsmmu_pkg::dsmmu_move_s m, input logic [3:0] s);
    mv_rd = m.rd && (m.sel == s);
  endfunction

  // Reports arriving while locked are dropped, not queued
  function automatic logic capture_ok(input dsmmu_pkg::dsmmu_fault_s f, input logic locked);
    capture_ok = !locked && (f.fault || f.tb_miss);
  endfunction

  function automatic logic [dsmmu_pkg::SYN_WIDTH-1:0] syn_pack(
    input dsmmu_pkg::dsmmu_fault_s f
  );
    logic [dsmmu_pkg::SYN_WIDTH-1:0] s;
    s = dsmmu_pkg::SYN_RESET;
    s[dsmmu_pkg::SYN_OP_LSB +: 6] = f.opcode;
    s[dsmmu_pkg::SYN_RA_LSB +: 5] = f.ra;
    s[dsmmu_pkg::SYN_FOR_BIT] = !f.is_write && f.pte_for;
    s[dsmmu_pkg::SYN_FOW_BIT] = f.is_write && f.pte_fow;
    s[dsmmu_pkg::SYN_ACV_BIT] = f.access_violation_flag;
    s[dsmmu_pkg::SYN_WR_BIT]  = f.is_write;
    syn_pack = s;
  endfunction

  always_comb
  begin
    lock_d = lock_q;
    // Address read unlocks; a report with the unlocking read is dropped, a capture while already unlocked relocks
    if (mv_rd(move, dsmmu_pkg::REG_FAULT_ADDRESS))
    begin
      lock_d = 1'b0;
    end
    if (capture_ok(fault_in, lock_q))
    begin
      lock_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_q <= 1'b0;
    end
    else
    begin
      lock_q <= lock_d;
    end
  end

  always_comb
  begin
    syn_d = syn_q;
    if (capture_ok(fault_in, lock_q))
    begin
      syn_d = syn_pack(fault_in);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syn_q <= dsmmu_pkg::SYN_RESET;
    end
    else
    begin
      syn_q <= syn_d;
    end
  end

  always_comb
  begin
    va_d = va_q;
    if (capture_ok(fault_in, lock_q))
    begin
      va_d = fault_va;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      va_q <= '0;
    end
    else
    begin
      va_q <= va_d;
    end
  end

  always_comb
  begin
    cmd_all_d = mv_wr(move, dsmmu_pkg::REG_TB_INV_ALL);
    cmd_ng_d  = mv_wr(move, dsmmu_pkg::REG_TB_INV_NONGLB);
    cmd_one_d = mv_wr(move, dsmmu_pkg::REG_TB_INV_SINGLE);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_all_q <= 1'b0;
      cmd_ng_q  <= 1'b0;
      cmd_one_q <= 1'b0;
    end
    else
    begin
      cmd_all_q <= cmd_all_d;
      cmd_ng_q  <= cmd_ng_d;
      cmd_one_q <= cmd_one_d;
    end
  end

  always_comb
  begin
    ic_all_d = mv_wr(move, dsmmu_pkg::REG_IC_INV_ALL);
    ic_ng_d  = mv_wr(move, dsmmu_pkg::REG_IC_INV_NONGLB);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ic_all_q <= 1'b0;
      ic_ng_q  <= 1'b0;
    end
    else
    begin
      ic_all_q <= ic_all_d;
      ic_ng_q  <= ic_ng_d;
    end
  end

  always_comb
  begin
    inv_va_d = inv_va_q;
    if (mv_wr(move, dsmmu_pkg::REG_TB_INV_SINGLE))
    begin
      inv_va_d = move_wdata[VA_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inv_va_q <= '0;
    end
    else
    begin
      inv_va_q <= inv_va_d;
    end
  end

  always_comb
  begin
    ctl_d = ctl_q;
    if (mv_wr(move, dsmmu_pkg::REG_ADDR_UNIT_CTL))
    begin
      // Bits 9 and 7 kept as written; software keeps them zero
      ctl_d = move_wdata[dsmmu_pkg::CTL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q <= dsmmu_pkg::CTL_RESET;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  always_comb
  begin
    rdata_d = 64'h0000000000000000;
    if (move.rd)
    begin
      case (move.sel)
        dsmmu_pkg::REG_FAULT_SYNDROME: rdata_d = {{(64-dsmmu_pkg::SYN_WIDTH){1'b0}}, syn_q};
        dsmmu_pkg::REG_FAULT_ADDRESS:  rdata_d = {{(64-VA_WIDTH){1'b0}}, va_q};
        default:                       rdata_d = 64'h0000000000000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 64'h0000000000000000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign move_rdata             = rdata_q;
  assign fault_locked           = lock_q;
  assign tb_inval_all           = cmd_all_q;
  assign nlu_pointer_reset      = cmd_all_q;
  assign tb_inval_nonglobal     = cmd_ng_q;
  assign tb_inval_single        = cmd_one_q;
  assign tb_inval_va            = inv_va_q;
  assign icache_inval_all       = ic_all_q;
  assign icache_inval_nonglobal = ic_ng_q;
  // Force hit overrides the enable bit
  assign dcache_force_hit       = ctl_q[dsmmu_pkg::CTL_FHIT_BIT];
  assign dcache_enable          = ctl_q[dsmmu_pkg::CTL_DCACHE_ENABLE_BIT] ||
                                  ctl_q[dsmmu_pkg::CTL_FHIT_BIT];
  // Flush held while disabled so no stale line survives re-enable
  assign dcache_flush           = !ctl_q[dsmmu_pkg::CTL_DCACHE_ENABLE_BIT];
  assign uncached_no_invalidate = ctl_q[dsmmu_pkg::CTL_NODIST_BIT];
  assign conditional_store_result_ctl = ctl_q[dsmmu_pkg::CTL_STC_BIT];
  // Changing this mid-run reorders live data; init time only
  assign big_endian_swap        = ctl_q[dsmmu_pkg::CTL_ENDIAN_BIT];
  assign pa_bit2_out            = pa_bit2_in ^ ctl_q[dsmmu_pkg::CTL_ENDIAN_BIT];

endmodule

// File: dsmmu_core_sva.sv
/* Port checker for dsmmu_core: commands, control bits and fault lock.
   Assumes the package is compiled first and the package selector encoding. */
module dsmmu_core_chk #(
  parameter int VA_WIDTH = 43
) (
  // Clock, reset and requests
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire dsmmu_pkg::dsmmu_fault_s fault_in,
  input wire dsmmu_pkg::dsmmu_move_s  move,
  input wire logic [63:0]             move_wdata,
  // Responses
  input wire logic                    tb_inval_all,
  input wire logic                    nlu_pointer_reset,
  input wire logic                    tb_inval_single,
  input wire logic [VA_WIDTH-1:0]     tb_inval_va,
  input wire logic                    dcache_force_hit,
  input wire logic                    dcache_enable,
  input wire logic                    dcache_flush,
  input wire logic                    uncached_no_invalidate,
  input wire logic                    big_endian_swap,
  input wire logic                    pa_bit2_in,
  input wire logic                    pa_bit2_out,
  input wire logic                    fault_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] wd_q;
  wire wctl = move.wr && move.sel == 4'h7;
  wire unlk = move.rd && move.sel == 4'h1;
  wire any  = fault_in.fault || fault_in.tb_miss;
  // Last write data, so the control checks avoid $past on slices
  always_ff @(posedge clk) wd_q <= move_wdata[11:0];
  AST_ZAP: assert property (
    move.wr && move.sel == 4'h2 |=> tb_inval_all && nlu_pointer_reset) else $error("zap");
  AST_TBIS: assert property (
    move.wr && move.sel == 4'h4 |=> tb_inval_single && tb_inval_va == $past(move_wdata[VA_WIDTH-1:0]))
    else $error("single");
  AST_DCEN: assert property (
    wctl |=> dcache_force_hit == wd_q[11] && dcache_enable == (wd_q[11] | wd_q[10])
    && dcache_flush == !wd_q[10]) else $error("dcache");
  AST_NODIST: assert property (
    wctl |=> uncached_no_invalidate == wd_q[8] && big_endian_swap == wd_q[6]) else $error("ctl");
  AST_ENDIAN: assert property (
    pa_bit2_out == (pa_bit2_in ^ big_endian_swap)) else $error("endian");
  AST_LOCK: assert property (
    any && !fault_locked |=> fault_locked) else $error("lock");
  AST_HOLD: assert property (
    fault_locked && !unlk |=> fault_locked) else $error("hold");
  AST_FREE: assert property (
    unlk && !any |=> !fault_locked) else $error("unlock");
  AST_RST: assert property (
    $rose(rst_n) |-> !fault_locked) else $error("reset lock");
endmodule
bind dsmmu_core dsmmu_core_chk #(.VA_WIDTH(VA_WIDTH)) chk_i (.clk, .rst_n, .fault_in, .move,
  .move_wdata, .tb_inval_all, .nlu_pointer_reset, .tb_inval_single, .tb_inval_va,
  .dcache_force_hit, .dcache_enable, .dcache_flush, .uncached_no_invalidate, .big_endian_swap,
  .pa_bit2_in, .pa_bit2_out, .fault_locked);

// File: dsmmu_core_tb.sv
/* Self-checking bench for dsmmu_core with a small reference model.
   Assumes the package, design and checker are compiled first. */
module dsmmu_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk = 1'b0, rst_n = 1'b0, pa_bit2_in = 1'b0;
  dsmmu_pkg::dsmmu_fault_s fault_in = '0, f;
  dsmmu_pkg::dsmmu_move_s  move = '0;
  logic [42:0]             fault_va = '0, v, tb_inval_va;
  logic [63:0]             move_wdata = '0, move_rdata, r, d;
  logic [14:0]             syn_m;
  logic                    tb_inval_all, tb_inval_nonglobal, tb_inval_single, nlu_pointer_reset;
  logic                    icache_inval_all, icache_inval_nonglobal, dcache_force_hit;
  logic                    dcache_enable, dcache_flush, uncached_no_invalidate, big_endian_swap;
  logic                    conditional_store_result_ctl, pa_bit2_out, fault_locked;
  logic                    swap;
  int                      seed = 32'heb38, bad_count = 0, checked = 0;
  dsmmu_core dsmmu_core_i (.clk, .rst_n, .fault_in, .fault_va, .move, .move_wdata, .move_rdata,
    .tb_inval_all, .tb_inval_nonglobal, .tb_inval_single, .tb_inval_va, .nlu_pointer_reset,
    .icache_inval_all, .icache_inval_nonglobal, .dcache_force_hit, .dcache_enable, .dcache_flush,
    .uncached_no_invalidate, .conditional_store_result_ctl, .big_endian_swap, .pa_bit2_in,
    .pa_bit2_out, .fault_locked);
  always #50 clk = ~clk;
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One register move; read data lands in r
  task mv(input logic w, input logic [3:0] s, input logic [63:0] dat);
    @(posedge clk);
    move <= '{w, !w, s};
    move_wdata <= dat;
    @(posedge clk);
    move <= '0;
    #1 r = move_rdata;
  endtask
  task flt(input dsmmu_pkg::dsmmu_fault_s fv, input logic [42:0] va);
    @(posedge clk);
    fault_in <= fv;
    fault_va <= va;
    @(posedge clk);
    fault_in <= '0;
    #1;
  endtask
  initial
  begin
    #5000000 bad_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(fault_locked, 0, "lock");
    chk(dcache_flush, 1, "flush");
    for (int i = 0; i < 8; i++)
    begin
      f = 16'($random(seed));
      f.fault = !i[0];
      f.tb_miss = i[0];
      v = 43'({$random(seed), $random(seed)});
      syn_m = {f.opcode, f.ra, f.is_write & f.pte_fow, !f.is_write & f.pte_for, f.access_violation_flag, f.is_write};
      flt(f, v);
      chk(fault_locked, 1, "locked");
      // A second fault while locked must leave both registers alone
      f.opcode = ~f.opcode;
      flt(f, ~v);
      mv(0, 4'h0, 0);
      chk(r, {49'h0, syn_m}, "syndrome");
      mv(0, 4'h1, 0);
      chk(r, {21'h0, v}, "address");
      chk(fault_locked, 0, "unlock");
    end
    for (int s = 2; s < 7; s++)
    begin
      d = {$random(seed), $random(seed)};
      mv(1, s[3:0], d);
      chk({tb_inval_all, tb_inval_nonglobal, tb_inval_single, icache_inval_all,
        icache_inval_nonglobal, nlu_pointer_reset}, {5'h10 >> (s - 2), s == 2}, "cmd");
      if (s == 4) chk(tb_inval_va, d[42:0], "inval va");
      mv(0, s[3:0], 0);
      chk(r, 0, "write only");
    end
    mv(0, 4'hF, 0);
    chk(r, 0, "unmapped");
    swap = 1'($random(seed));
    for (int i = 0; i < 6; i++)
    begin
      d = 64'($random(seed)) & 64'hD7F;
      if (i < 2) d = i ? 64'h800 : 64'h400;
      d[6] = swap;
      mv(1, 4'h7, d);
      @(posedge clk);
      pa_bit2_in <= d[0];
      #1 chk({dcache_force_hit, dcache_enable, dcache_flush, uncached_no_invalidate, big_endian_swap,
        pa_bit2_out, conditional_store_result_ctl},
        {d[11], d[11] | d[10], !d[10], d[8], d[6], d[0] ^ d[6], d[7]}, "ctl");
    end
    // Writes to the read-only registers must leave them alone
    f.opcode = ~f.opcode;
    flt(f, v);
    mv(1, 4'h1, ~v);
    mv(1, 4'h0, 0);
    chk(fault_locked, 1, "ro write");
    mv(0, 4'h0, 0);
    chk(r, {49'h0, syn_m}, "ro syndrome");
    mv(0, 4'h1, 0);
    chk(r, {21'h0, v}, "ro address");
    flt(f, ~v);
    chk(fault_locked, 1, "relock");
    // Reset while locked; the endian choice may change only at this re-init
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(fault_locked, 0, "reset lock");
    chk(dcache_flush, 1, "reset flush");
    mv(1, 4'h7, {57'h0, !swap, 6'h00});
    #1 chk({big_endian_swap, pa_bit2_out}, {!swap, pa_bit2_in ^ !swap}, "reinit swap");
    report_and_stop;
  end
endmodule

// File: dsmmu_pkg.sv
/*
  Shared constants and carriers for the data-stream fault and translation-buffer control block.
  Assumes a single CPU clock and internal register moves decoded by the instruction pipeline.
*/
package dsmmu_pkg;

  // Internal register selectors (arbitrary encodings of the move port)
  localparam logic [3:0] REG_FAULT_SYNDROME = 4'h0;
  localparam logic [3:0] REG_FAULT_ADDRESS  = 4'h1;
  localparam logic [3:0] REG_TB_INV_ALL     = 4'h2;
  localparam logic [3:0] REG_TB_INV_NONGLB  = 4'h3;
  localparam logic [3:0] REG_TB_INV_SINGLE  = 4'h4;
  localparam logic [3:0] REG_IC_INV_ALL     = 4'h5;
  localparam logic [3:0] REG_IC_INV_NONGLB  = 4'h6;
  localparam logic [3:0] REG_ADDR_UNIT_CTL  = 4'h7;

  // Syndrome field positions
  localparam int SYN_WR_BIT  = 0;
  localparam int SYN_ACV_BIT = 1;
  localparam int SYN_FOR_BIT = 2;
  localparam int SYN_FOW_BIT = 3;
  localparam int SYN_RA_LSB  = 4;
  localparam int SYN_OP_LSB  = 9;
  localparam int SYN_WIDTH   = 15;

  // Control field positions
  localparam int CTL_ENDIAN_BIT  = 6;
  localparam int CTL_STC_BIT     = 7;
  localparam int CTL_NODIST_BIT  = 8;
  localparam int CTL_MBZ_BIT     = 9;
  localparam int CTL_DCACHE_ENABLE_BIT   = 10;
  localparam int CTL_FHIT_BIT    = 11;
  localparam int CTL_WIDTH       = 12;

  // Reset values
  localparam logic [SYN_WIDTH-1:0] SYN_RESET = 15'h0000;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 12'h000;

  // Translation buffer geometry
  localparam int TB_SMALL_ENTRIES = 32;
  localparam int TB_LARGE_ENTRIES = 4;

  // Fault report from the address pipeline
  typedef struct packed {
    logic       fault;
    logic       tb_miss;
    logic [5:0] opcode;
    logic [4:0] ra;
    logic       is_write;
    logic       access_violation_flag;
    logic       pte_for;
    logic       pte_fow;
  } dsmmu_fault_s;

  // Internal register move
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] sel;
  } dsmmu_move_s;

endpackage
